//--- design/gadc_sequencer.v
// conversion sequencer for the general adc: one-shot and periodic paths
`timescale 1ns/1ns
`default_nettype none
`include "gadc_consts.vh"
module gadc_sequencer #(
    parameter RW       = `GADC_RES_W,
    parameter CW       = `GADC_CH_W,
    parameter TICK_DIV = `GADC_TICK_DIV,
    parameter PWR_CYC  = `GADC_PWR_UP_CYC
) (
    input  wire                     core_clk_i,
    input  wire                     reset_i,
    // one-shot request
    input  wire [CW-1:0]            oneshot_channel_i,
    input  wire                     oneshot_start_i,
    output reg                      oneshot_done_irq_o,
    output reg  [`GADC_LOW_W-1:0]   oneshot_result_low_o,
    output reg  [`GADC_HIGH_W-1:0]  oneshot_result_high_o,
    // periodic control
    input  wire [CW-1:0]            slot_a_channel_field_i,
    input  wire [CW-1:0]            slot_b_channel_field_i,
    input  wire                     slot_a_enable_i,
    input  wire                     slot_b_enable_i,
    input  wire                     slot_a_shutdown_en_i,
    input  wire                     slot_b_shutdown_en_i,
    input  wire [`GADC_IVL_W-1:0]   interval_sel_i,
    input  wire [`GADC_LOW_W-1:0]   slot_a_threshold_low_i,
    input  wire [`GADC_HIGH_W-1:0]  slot_a_threshold_high_i,
    input  wire                     slot_a_polarity_i,
    input  wire [`GADC_LOW_W-1:0]   slot_b_threshold_low_i,
    input  wire [`GADC_HIGH_W-1:0]  slot_b_threshold_high_i,
    input  wire                     slot_b_polarity_i,
    output reg  [`GADC_LOW_W-1:0]   slot_a_result_low_o,
    output reg  [`GADC_HIGH_W-1:0]  slot_a_result_high_o,
    output reg  [`GADC_LOW_W-1:0]   slot_b_result_low_o,
    output reg  [`GADC_HIGH_W-1:0]  slot_b_result_high_o,
    output reg                      slot_a_cross_irq_o,
    output reg                      slot_b_cross_irq_o,
    output reg                      shutdown_req_o,
    // power state and thermal sensor
    input  wire [1:0]               power_state_i,
    input  wire                     thermal_sensor_on_i,
    // converter core
    output reg                      conv_power_o,
    output reg                      conv_start_o,
    output reg  [CW-1:0]            conv_channel_o,
    input  wire                     conv_done_i,
    input  wire [RW-1:0]            conv_data_i,
    // calibration trims
    input  wire                     trim_prog_en_i,
    input  wire [`GADC_TRIM_IDX_W-1:0] trim_prog_addr_i,
    input  wire [`GADC_TRIM_W-1:0]  trim_prog_data_i,
    input  wire [`GADC_TRIM_IDX_W-1:0] trim_rd_addr_i,
    output wire [`GADC_TRIM_W-1:0]  trim_rd_data_o
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_PWRUP = 3'h1;
    localparam ST_START = 3'h2;
    localparam ST_WAIT  = 3'h3;
    localparam ST_NEXT  = 3'h4;

    // channel allowed in the current power state
    function allowed;
        input [CW-1:0] ch;
        input [1:0]    pst;
        input          therm;
        begin
            if (pst == `GADC_PSTATE_ACT)
                allowed = 1'b1;
            else if (ch <= `GADC_LAST_LOW_CH)
                allowed = 1'b1;
            else if (pst == `GADC_PSTATE_SLEEP && therm &&
                     (ch == `GADC_THERM_CH_A || ch == `GADC_THERM_CH_B))
                allowed = 1'b1;
            else
                allowed = 1'b0;
        end
    endfunction

    // threshold test: polarity 1 trips above, polarity 0 trips below
    function crossed;
        input [RW-1:0] val;
        input [RW-1:0] thr;
        input          pol;
        begin
            crossed = pol ? (val > thr) : (val < thr);
        end
    endfunction

    reg [2:0]    state;
    reg          pend_shot;
    reg [CW-1:0] shot_ch;
    reg          pend_per;
    reg          busy_shot;
    reg          cur_slot_b;
    reg          second_pending;
    reg [CW-1:0] second_ch;
    reg [9:0]    pwr_cnt;
    reg [7:0]    tick_div;
    reg          tick;
    reg [15:0]   ivl_cnt;
    reg [15:0]   ivl_limit;

    // interval choices in divider ticks (1 us each at the default divider)
    always @*
    begin
        case (interval_sel_i)
            2'h0:    ivl_limit = 16'h03E8;
            2'h1:    ivl_limit = 16'h07D0;
            2'h2:    ivl_limit = 16'h1388;
            default: ivl_limit = 16'h2710;
        endcase
    end

    wire a_ok = slot_a_enable_i && allowed(slot_a_channel_field_i, power_state_i, thermal_sensor_on_i);
    wire b_ok = slot_b_enable_i && allowed(slot_b_channel_field_i, power_state_i, thermal_sensor_on_i);
    // ascending channel order; on a tie slot a goes first; first result lands in slot a unless only slot b converts
    wire b_first = a_ok && b_ok && (slot_b_channel_field_i < slot_a_channel_field_i);
    wire [RW-1:0] thr_a = {slot_a_threshold_high_i, slot_a_threshold_low_i};
    wire [RW-1:0] thr_b = {slot_b_threshold_high_i, slot_b_threshold_low_i};

    gadc_trim_mem u_trim (
        .core_clk_i  (core_clk_i),
        .reset_i     (reset_i),
        .prog_en_i   (trim_prog_en_i),
        .prog_addr_i (trim_prog_addr_i),
        .prog_data_i (trim_prog_data_i),
        .rd_addr_i   (trim_rd_addr_i),
        .rd_data_o   (trim_rd_data_o)
    );

    // period timer; keeps running whatever the state of events or results
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tick_div <= 8'h00;
            tick     <= 1'b0;
            ivl_cnt  <= 16'h0000;
            pend_per <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            // cleared before the interval test so a new interval in the same cycle wins
            if (state == ST_IDLE && !pend_shot && pend_per)
                pend_per <= 1'b0;
            if (tick_div == TICK_DIV - 1)
            begin
                tick_div <= 8'h00;
                tick     <= 1'b1;
            end
            else
                tick_div <= tick_div + 8'h01;
            if (!(slot_a_enable_i || slot_b_enable_i))
                ivl_cnt <= 16'h0000;
            else if (tick)
            begin
                if (ivl_cnt >= ivl_limit - 16'h0001)
                begin
                    ivl_cnt  <= 16'h0000;
                    pend_per <= 1'b1;
                end
                else
                    ivl_cnt <= ivl_cnt + 16'h0001;
            end
        end
    end

    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state                 <= ST_IDLE;
            pend_shot             <= 1'b0;
            shot_ch               <= {CW{1'b0}};
            busy_shot             <= 1'b0;
            cur_slot_b            <= 1'b0;
            second_pending        <= 1'b0;
            second_ch             <= {CW{1'b0}};
            pwr_cnt               <= 10'h000;
            conv_power_o          <= 1'b0;
            conv_start_o          <= 1'b0;
            conv_channel_o        <= {CW{1'b0}};
            oneshot_done_irq_o    <= 1'b0;
            oneshot_result_low_o  <= 8'h00;
            oneshot_result_high_o <= 4'h0;
            slot_a_result_low_o   <= 8'h00;
            slot_a_result_high_o  <= 4'h0;
            slot_b_result_low_o   <= 8'h00;
            slot_b_result_high_o  <= 4'h0;
            slot_a_cross_irq_o    <= 1'b0;
            slot_b_cross_irq_o    <= 1'b0;
            shutdown_req_o        <= 1'b0;
        end
        else
        begin
            conv_start_o       <= 1'b0;
            oneshot_done_irq_o <= 1'b0;
            slot_a_cross_irq_o <= 1'b0;
            slot_b_cross_irq_o <= 1'b0;
            shutdown_req_o     <= 1'b0;
            // a request is latched with the channel present at that moment
            if (oneshot_start_i && !(state != ST_IDLE && busy_shot))
            begin
                pend_shot <= 1'b1;
                shot_ch   <= oneshot_channel_i;
            end
            case (state)
                ST_IDLE:
                begin
                    conv_power_o <= 1'b0;
                    if (pend_shot && allowed(shot_ch, power_state_i, thermal_sensor_on_i))
                    begin
                        busy_shot      <= 1'b1;
                        pend_shot      <= oneshot_start_i;
                        conv_channel_o <= shot_ch;
                        state          <= ST_PWRUP;
                    end
                    else if (pend_per && (a_ok || b_ok))
                    begin
                        busy_shot      <= 1'b0;
                        cur_slot_b     <= !a_ok;
                        second_pending <= a_ok && b_ok;
                        second_ch      <= b_first ? slot_a_channel_field_i : slot_b_channel_field_i;
                        conv_channel_o <= (b_first || !a_ok) ? slot_b_channel_field_i : slot_a_channel_field_i;
                        state          <= ST_PWRUP;
                    end
                    else if (pend_shot)
                        pend_shot <= oneshot_start_i; // disallowed channel is dropped
                    pwr_cnt <= 10'h000;
                end
                ST_PWRUP:
                begin
                    conv_power_o <= 1'b1;
                    if (pwr_cnt == PWR_CYC - 1)
                        state <= ST_START;
                    else
                        pwr_cnt <= pwr_cnt + 10'h001;
                end
                ST_START:
                begin
                    conv_start_o <= 1'b1;
                    state        <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (conv_done_i)
                    begin
                        if (busy_shot)
                        begin
                            oneshot_result_low_o  <= conv_data_i[7:0];
                            oneshot_result_high_o <= conv_data_i[11:8];
                            oneshot_done_irq_o    <= 1'b1;
                            state                 <= ST_IDLE;
                        end
                        else if (!cur_slot_b)
                        begin
                            slot_a_result_low_o  <= conv_data_i[7:0];
                            slot_a_result_high_o <= conv_data_i[11:8];
                            if (crossed(conv_data_i, thr_a, slot_a_polarity_i))
                            begin
                                slot_a_cross_irq_o <= 1'b1;
                                shutdown_req_o     <= slot_a_shutdown_en_i;
                            end
                            state <= ST_NEXT;
                        end
                        else
                        begin
                            slot_b_result_low_o  <= conv_data_i[7:0];
                            slot_b_result_high_o <= conv_data_i[11:8];
                            if (crossed(conv_data_i, thr_b, slot_b_polarity_i))
                            begin
                                slot_b_cross_irq_o <= 1'b1;
                                shutdown_req_o     <= slot_b_shutdown_en_i;
                            end
                            state <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT:
                begin
                    // converter stays powered between the two queued channels
                    if (second_pending)
                    begin
                        second_pending <= 1'b0;
                        cur_slot_b     <= 1'b1;
                        conv_channel_o <= second_ch;
                        state          <= ST_START;
                    end
                    else
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule // gadc_sequencer
`default_nettype wire

//--- design/gadc_consts.vh
// constants for the general adc conversion sequencer
// How it works
// - 12-bit converter behind an eight-input mux, channels 0 to 7.
// - pending one-shot request is served before a pending periodic conversion.
// - one-shot completion pulses the done event and loads the one-shot result.
// - periodic mode converts one or two selected channels against own thresholds.
// - each slot has its own threshold value and comparison polarity.
// - converter power is switched automatically around conversions.
// - latest periodic results always land in the slot result registers, lower channel in slot a.
// - periodic channels run in ascending order; lower result to the first slot.
// - threshold crossing raises an event and keeps the result stored.
// - unread results are overwritten by newer ones.
// - periodic conversion never stops for pending events or unread results.
// - crossing also requests shutdown when that slot's shutdown bit is set.
// - in sleep and off only channels 0 to 4 are converted, except 5 and 6 in sleep as below.
// - in sleep channels 5 and 6 convert only while the thermal sensor is on.
// - six one-time programmable calibration trims are readable by the host.
`ifndef GADC_CONSTS_VH
`define GADC_CONSTS_VH
`define GADC_RES_W        12
`define GADC_LOW_W        8
`define GADC_HIGH_W       4
`define GADC_CH_W         3
`define GADC_LAST_LOW_CH  3'h4
`define GADC_THERM_CH_A   3'h5
`define GADC_THERM_CH_B   3'h6
`define GADC_PWR_UP_NS    1000
`define GADC_CLK_NS       50
`define GADC_PWR_UP_CYC   ((`GADC_PWR_UP_NS + `GADC_CLK_NS - 1) / `GADC_CLK_NS)
`define GADC_TICK_DIV     20
`define GADC_IVL_W        2
`define GADC_PSTATE_ACT   2'h0
`define GADC_PSTATE_SLEEP 2'h1
`define GADC_PSTATE_OFF   2'h2
`define GADC_TRIM_COUNT   6
`define GADC_TRIM_W       8
`define GADC_TRIM_IDX_W   3
`endif

//--- design/gadc_trim_mem.v
// small storage for the calibration trims, registered read data
`timescale 1ns/1ns
`default_nettype none
`include "gadc_consts.vh"
module gadc_trim_mem #(
    parameter DEPTH = `GADC_TRIM_COUNT,
    parameter WIDTH = `GADC_TRIM_W,
    parameter AW    = `GADC_TRIM_IDX_W
) (
    input  wire             core_clk_i,
    input  wire             reset_i,
    input  wire             prog_en_i,
    input  wire [AW-1:0]    prog_addr_i,
    input  wire [WIDTH-1:0] prog_data_i,
    input  wire [AW-1:0]    rd_addr_i,
    output reg  [WIDTH-1:0] rd_data_o
);
    wire [DEPTH*WIDTH-1:0] flat;
    genvar g;
    // one-time programmable: each word accepts a single write after reset
    // words live in their own registers so every flop has a single process
    generate
        for (g = 0; g < DEPTH; g = g + 1)
        begin : g_word
            reg [WIDTH-1:0] word;
            reg             burnt;
            always @(posedge core_clk_i or posedge reset_i)
            begin
                if (reset_i)
                begin
                    word  <= {WIDTH{1'b0}};
                    burnt <= 1'b0;
                end
                else if (prog_en_i && !burnt && prog_addr_i == g)
                begin
                    word  <= prog_data_i;
                    burnt <= 1'b1;
                end
            end
            assign flat[g*WIDTH +: WIDTH] = word;
        end
    endgenerate
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            rd_data_o <= {WIDTH{1'b0}};
        else if (rd_addr_i < DEPTH)
            rd_data_o <= flat[rd_addr_i*WIDTH +: WIDTH];
        else
            rd_data_o <= {WIDTH{1'b0}};
    end
endmodule // gadc_trim_mem
`default_nettype wire

//--- sim/gadc_seq_chk_assertions.sv
// concurrent checks on the conversion sequencer ports
`timescale 1ns/1ns
`default_nettype none
module gadc_seq_chk (
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic        oneshot_done_irq_o,
    input wire logic [7:0]  oneshot_result_low_o,
    input wire logic [3:0]  oneshot_result_high_o,
    input wire logic        conv_done_i,
    input wire logic [11:0] conv_data_i,
    input wire logic        conv_power_o,
    input wire logic        conv_start_o,
    input wire logic [2:0]  conv_channel_o,
    input wire logic [1:0]  power_state_i,
    input wire logic        thermal_sensor_on_i,
    input wire logic [7:0]  slot_a_result_low_o,
    input wire logic [3:0]  slot_a_result_high_o,
    input wire logic [7:0]  slot_a_threshold_low_i,
    input wire logic [3:0]  slot_a_threshold_high_i,
    input wire logic        slot_a_polarity_i,
    input wire logic        slot_a_cross_irq_o,
    input wire logic        slot_b_cross_irq_o,
    input wire logic        slot_a_shutdown_en_i,
    input wire logic        slot_b_shutdown_en_i,
    input wire logic        shutdown_req_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire [11:0] res_a = {slot_a_result_high_o, slot_a_result_low_o};
    wire [11:0] thr_a = {slot_a_threshold_high_i, slot_a_threshold_low_i};
    done_cause_a: assert property (oneshot_done_irq_o |-> $past(conv_done_i))
        else $error("one-shot done without converter done");
    done_pulse_a: assert property (oneshot_done_irq_o |=> !oneshot_done_irq_o)
        else $error("one-shot done longer than one cycle");
    result_split_a: assert property (oneshot_done_irq_o |->
        {oneshot_result_high_o, oneshot_result_low_o} == $past(conv_data_i))
        else $error("one-shot result split wrong");
    power_up_a: assert property (conv_start_o |-> conv_power_o && $past(conv_power_o, 18))
        else $error("start without converter powered up");
    sleep_channel_a: assert property (conv_start_o && power_state_i != 2'h0 |-> conv_channel_o <= 3'h4 ||
        (power_state_i == 2'h1 && thermal_sensor_on_i && conv_channel_o inside {3'h5, 3'h6}))
        else $error("channel converted in low power state");
    slot_load_a: assert property (!$stable(res_a) |-> $past(conv_done_i))
        else $error("slot result changed without conversion");
    cross_rule_a: assert property (slot_a_cross_irq_o |-> $past(conv_done_i) &&
        (slot_a_polarity_i ? res_a > thr_a : res_a < thr_a))
        else $error("slot crossing against threshold wrong");
    shutdown_cause_a: assert property (shutdown_req_o |-> slot_a_cross_irq_o && slot_a_shutdown_en_i ||
        slot_b_cross_irq_o && slot_b_shutdown_en_i)
        else $error("shutdown without enabled crossing");
    shutdown_given_a: assert property (slot_a_cross_irq_o && slot_a_shutdown_en_i |-> shutdown_req_o)
        else $error("enabled crossing without shutdown");
    cover property (oneshot_done_irq_o);
    cover property (slot_a_cross_irq_o && shutdown_req_o);
    cover property (conv_start_o && power_state_i == 2'h1);
endmodule // gadc_seq_chk
bind gadc_sequencer gadc_seq_chk chk (.*);
`default_nettype wire

//--- sim/gadc_core_model.sv
// behavioural converter core answering start pulses
`timescale 1ns/1ns
`default_nettype none
module gadc_core_model (
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic [2:0]  channel_i,
    input  wire logic [11:0] base_i,
    input  wire logic [3:0]  latency_i,
    output logic             done_o,
    output logic [11:0]      data_o
);
    logic [11:0] value;
    initial
    begin
        done_o = 1'b0;
        data_o = 12'hA5A;
    end
    // data means nothing away from done, so it is inverted there
    always @(posedge clk_i)
    begin
        if (start_i === 1'b1)
        begin
            value = base_i + {9'h000, channel_i};
            repeat (latency_i + 1) @(posedge clk_i);
            done_o <= 1'b1;
            data_o <= value;
            @(posedge clk_i);
            done_o <= 1'b0;
            data_o <= ~value;
        end
    end
endmodule // gadc_core_model
`default_nettype wire

//--- sim/gadc_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        core_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [2:0]  oneshot_channel_i, slot_a_channel_field_i, slot_b_channel_field_i, conv_channel_o;
    logic [2:0]  trim_prog_addr_i, trim_rd_addr_i;
    logic [1:0]  interval_sel_i, power_state_i;
    logic [7:0]  oneshot_result_low_o, slot_a_threshold_low_i, slot_b_threshold_low_i, trim_rd_data_o;
    logic [7:0]  slot_a_result_low_o, slot_b_result_low_o, trim_prog_data_i;
    logic [3:0]  oneshot_result_high_o, slot_a_threshold_high_i, slot_b_threshold_high_i, latency;
    logic [3:0]  slot_a_result_high_o, slot_b_result_high_o;
    logic [11:0] conv_data_i, base;
    logic        oneshot_start_i, oneshot_done_irq_o, slot_a_enable_i, slot_b_enable_i;
    logic        slot_a_shutdown_en_i, slot_b_shutdown_en_i, slot_a_polarity_i, slot_b_polarity_i;
    logic        slot_a_cross_irq_o, slot_b_cross_irq_o, shutdown_req_o, thermal_sensor_on_i;
    logic        conv_power_o, conv_start_o, conv_done_i, trim_prog_en_i;
    logic        done_seen = 1'b0;
    logic [14:0] notes[$];
    logic [14:0] note;
    logic [7:0]  trims[6];
    logic [6:0]  cases[6] = '{7'h3B, 7'h2C, 7'h3E, 7'h5A, 7'h49, 7'h21};
    int          errors = 0;
    int          compares = 0;
    int          dones = 0;
    gadc_sequencer #(.TICK_DIV(1)) dut (.*);
    gadc_core_model core (.clk_i(core_clk_i), .start_i(conv_start_o), .channel_i(conv_channel_o),
        .base_i(base), .latency_i(latency), .done_o(conv_done_i), .data_o(conv_data_i));
    always #25 core_clk_i = ~core_clk_i;
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // refusals leave nothing to wait for, so at least 40 cycles always pass
    task automatic settle(input int lim);
        for (int i = 0; i < lim && (i < 40 || notes.size() != 0 || conv_power_o !== 1'b0); i++)
            @(posedge core_clk_i);
    endtask
    always @(posedge core_clk_i) done_seen <= conv_done_i;
    always @(negedge core_clk_i)
    begin
        if (done_seen === 1'b1)
        begin
            dones++;
            note = notes.size() ? notes.pop_front() : 15'h7FFF;
            case (note[13:12])
                2'h0:
                begin
                    check("oneshot", {oneshot_result_high_o, oneshot_result_low_o}, note[11:0]);
                    check("oneshot done", oneshot_done_irq_o, 1'b1);
                end
                2'h1:
                begin
                    check("slot a", {slot_a_result_high_o, slot_a_result_low_o}, note[11:0]);
                    check("slot a cross", slot_a_cross_irq_o, note[14]);
                    check("shutdown a", shutdown_req_o, note[14]);
                end
                2'h2:
                begin
                    check("slot b", {slot_b_result_high_o, slot_b_result_low_o}, note[11:0]);
                    check("slot b cross", slot_b_cross_irq_o, note[14]);
                    check("shutdown b", shutdown_req_o, note[14]);
                end
                default: check("note queue", 12'h001, 12'h000);
            endcase
        end
    end
    task automatic oneshot(input logic [1:0] ps, input logic th, input logic [2:0] ch, input logic ok);
        int n;
        @(posedge core_clk_i);
        power_state_i <= ps;
        thermal_sensor_on_i <= th;
        oneshot_channel_i <= ch;
        latency <= $urandom % 16;
        base <= $urandom % 4000;
        @(posedge core_clk_i);
        oneshot_start_i <= 1'b1;
        n = dones;
        if (ok)
            notes.push_back({3'h0, base + {9'h000, ch}});
        @(posedge core_clk_i);
        oneshot_start_i <= 1'b0;
        settle(400);
        check("conversions", dones - n, ok);
    endtask
    task automatic periodic(input logic [2:0] ca, input logic [2:0] cb, input logic [1:0] sel);
        logic [11:0] lo, hi, ta, tb2, nb;
        logic        pa, pb;
        @(posedge core_clk_i);
        power_state_i <= 2'h0;
        interval_sel_i <= sel;
        slot_a_channel_field_i <= ca;
        slot_b_channel_field_i <= cb;
        for (int r = 0; r < 3; r++)
        begin
            nb = $urandom % 4000;
            ta = $urandom % 4096;
            tb2 = $urandom % 4096;
            pa = $urandom % 2;
            pb = $urandom % 2;
            lo = nb + (ca < cb ? ca : cb);
            hi = nb + (ca < cb ? cb : ca);
            base <= nb;
            latency <= $urandom % 16;
            {slot_a_threshold_high_i, slot_a_threshold_low_i} <= ta;
            {slot_b_threshold_high_i, slot_b_threshold_low_i} <= tb2;
            slot_a_polarity_i <= pa;
            slot_b_polarity_i <= pb;
            notes.push_back({(pa ? lo > ta : lo < ta), 2'h1, lo});
            notes.push_back({(pb ? hi > tb2 : hi < tb2), 2'h2, hi});
            slot_a_enable_i <= 1'b1;
            slot_b_enable_i <= 1'b1;
            // results are never read between rounds
            settle(10200);
            @(posedge core_clk_i);
        end
        slot_a_enable_i <= 1'b0;
        slot_b_enable_i <= 1'b0;
    endtask
    initial
    begin
        repeat (50000) @(posedge core_clk_i);
        errors++;
        give_verdict;
    end
    initial
    begin
        void'($urandom(32'h03859FB1));
        {oneshot_channel_i, slot_a_channel_field_i, slot_b_channel_field_i, trim_prog_addr_i} = 12'h000;
        {trim_rd_addr_i, interval_sel_i, power_state_i, latency, base} = 23'h000000;
        {slot_a_threshold_low_i, slot_b_threshold_low_i, trim_prog_data_i} = 24'h000000;
        {slot_a_threshold_high_i, slot_b_threshold_high_i} = 8'h00;
        {oneshot_start_i, slot_a_enable_i, slot_b_enable_i, slot_a_polarity_i, slot_b_polarity_i} = 5'h00;
        {slot_a_shutdown_en_i, slot_b_shutdown_en_i, thermal_sensor_on_i, trim_prog_en_i} = 4'h0;
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            trims[i] = $urandom;
            @(posedge core_clk_i);
            trim_prog_en_i <= 1'b1;
            trim_prog_addr_i <= i[2:0];
            trim_prog_data_i <= trims[i];
        end
        @(posedge core_clk_i);
        trim_prog_en_i <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge core_clk_i);
            trim_rd_addr_i <= i[2:0];
            @(posedge core_clk_i);
            @(negedge core_clk_i);
            check("trim", trim_rd_data_o, i < 6 ? trims[i] : 8'h00);
        end
        // a host throws this first result away; the core model has no such flaw, so it is checked
        oneshot(2'h0, 1'b0, $urandom % 8, 1'b1);
        oneshot(2'h0, 1'b1, 3'h7, 1'b1);
        foreach (cases[i])
            oneshot(cases[i][6:5], cases[i][4], cases[i][3:1], cases[i][0]);
        slot_a_shutdown_en_i <= 1'b1;
        slot_b_shutdown_en_i <= 1'b1;
        periodic(3'h3, 3'h1, $urandom % 2);
        periodic(3'h1, 3'h3, 2'h2 + $urandom % 2);
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
